/* File: core/psl_consts.svh */
`ifndef PSL_CONSTS_SVH
`define PSL_CONSTS_SVH
// ==========================================
// word layout
`define PSL_WORD_W        24
`define PSL_ADDR_CTRL     2'h0
`define PSL_ADDR_REF      2'h1
`define PSL_ADDR_FB       2'h2
// control word fields
`define PSL_CTL_CORE_LSB  2
`define PSL_CTL_CLEAR     4
`define PSL_CTL_MUX_LSB   5
`define PSL_CTL_POL       8
`define PSL_CTL_TRI       9
`define PSL_CTL_GAIN      10
// feedback word fields
`define PSL_FB_DIV_LSB    2
`define PSL_FB_CNT_LSB    8
`define PSL_FB_GAIN       21
// reference word fields
`define PSL_REF_CNT_LSB   2
`define PSL_REF_BL_LSB    16
`define PSL_REF_LDP       18
`define PSL_REF_TEST      19
`define PSL_REF_BAND_LSB  20
// lock detect cycle counts
`define PSL_LOCK_CYC_HI   3'h5
`define PSL_LOCK_CYC_LO   3'h3
// serial clock ceiling, MHz, and system clock
`define PSL_SCLK_MAX_MHZ  20
`define PSL_SYS_MHZ       50
`endif

/* File: core/psl_latch_bank.sv */
`timescale 1ns/1ns
`include "psl_consts.svh"
// Contract
// - control gain bit one selects current setting 2, zero setting 1.
// - control bit DB9 one three-states the charge pump.
// - polarity bit one positive, zero negative detector polarity.
// - three-bit control field drives auxiliary output multiplexer selects.
// - control bit DB4 one holds reference and feedback counters reset; only feedback_hold_n is driven here, no reference counter hold.
// - two-bit core power field selects oscillator core current.
// - five-bit output divider accepts 2 to 31, zero when unused.
// - 13-bit feedback count sets ratio 3 to 8191.
// - total feedback division equals the feedback count, no prescaler.
// - shared gain bit follows latest write through either latch.
// - address bits (0,1) load the reference latch.
// - 14-bit reference count sets ratio 1 to 16383.
// - reference bits DB16-17 select antibacklash width.
// - precision bit picks five or three lock cycles.
// - test bit zero means test latch ignored.
// - two-bit field enables band-select clock divider.
// - one bit per rising serial clock; strobe rise loads word.
// - address bits (0,0) load the control latch.
// - serial register keeps loading during power-down.
module psl_latch_bank
    import psl_pkg::*;
(
    // system
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    // serial pins
    input  wire logic        serial_clk,
    input  wire logic        serial_data,
    input  wire logic        load_strobe,
    // power-down state, serial path stays live regardless
    input  wire logic        power_down,
    // decoded configuration
    output psl_cfg_t         cfg,
    output logic             feedback_hold_n,
    output logic [12:0]      total_feedback_div,
    output logic             load_done
);
    // ==========================================
    // state
    psl_state_t s_reg;
    psl_state_t s_next;
    logic       clk_rise;
    logic       le_rise;
    logic       clk_agree;
    logic       le_agree;
    logic [1:0] addr;

    always_comb begin
        s_next     = s_reg;
        clk_agree  = (s_reg.clk_sync[2] == s_reg.clk_sync[1]);
        le_agree   = (s_reg.le_sync[2] == s_reg.le_sync[1]);
        clk_rise   = clk_agree && s_reg.clk_sync[1] && !s_reg.clk_state;
        le_rise    = le_agree && s_reg.le_sync[1] && !s_reg.le_state;
        addr       = s_reg.shift[1:0];
        s_next.load_pulse = 1'b0;
        s_next.clk_sync = {s_reg.clk_sync[1:0], serial_clk};
        s_next.dat_sync = {s_reg.dat_sync[1:0], serial_data};
        s_next.le_sync  = {s_reg.le_sync[1:0], load_strobe};
        if (clk_agree) begin
            s_next.clk_state = s_reg.clk_sync[1];
        end
        if (le_agree) begin
            s_next.le_state = s_reg.le_sync[1];
        end
        // shift on clock rise
        // data tap is one stage later so it matches the clock edge age
        if (clk_rise) begin
            s_next.shift = {s_reg.shift[22:0], s_reg.dat_sync[2]};
        end
        if (le_rise) begin
            s_next.load_pulse = 1'b1;
            case (addr)
                `PSL_ADDR_CTRL: begin
                    s_next.ctrl_word = s_reg.shift;
                    s_next.gain = s_reg.shift[`PSL_CTL_GAIN];
                end
                `PSL_ADDR_REF: begin
                    s_next.ref_word = s_reg.shift;
                end
                `PSL_ADDR_FB: begin
                    s_next.fb_word = s_reg.shift;
                    s_next.gain = s_reg.shift[`PSL_FB_GAIN];
                end
                default: begin
                    // test latch is not kept
                    s_next.load_pulse = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else if (clk_en) begin
            s_reg <= s_next;
        end
    end

    // ==========================================
    // field decode
    always_comb begin
        cfg = '0;
        cfg.pump_gain_sel = s_reg.gain;
        cfg.pump_three_state = s_reg.ctrl_word[`PSL_CTL_TRI];
        cfg.detector_polarity = s_reg.ctrl_word[`PSL_CTL_POL];
        cfg.aux_mux_sel = s_reg.ctrl_word[`PSL_CTL_MUX_LSB +: 3];
        cfg.counters_clear = s_reg.ctrl_word[`PSL_CTL_CLEAR];
        cfg.core_current_sel = s_reg.ctrl_word[`PSL_CTL_CORE_LSB +: 2];
        cfg.out_div = s_reg.fb_word[`PSL_FB_DIV_LSB +: 5];
        cfg.feedback_count = s_reg.fb_word[`PSL_FB_CNT_LSB +: 13];
        cfg.ref_count = s_reg.ref_word[`PSL_REF_CNT_LSB +: 14];
        cfg.backlash_width = s_reg.ref_word[`PSL_REF_BL_LSB +: 2];
        cfg.lock_precision_sel = s_reg.ref_word[`PSL_REF_LDP];
        cfg.lock_cycles = s_reg.ref_word[`PSL_REF_LDP] ?
                          `PSL_LOCK_CYC_HI : `PSL_LOCK_CYC_LO;
        cfg.factory_test_flag = s_reg.ref_word[`PSL_REF_TEST];
        cfg.band_clk_div = s_reg.ref_word[`PSL_REF_BAND_LSB +: 2];
    end

    // counters held while clear set or powered down
    assign feedback_hold_n = !(cfg.counters_clear || power_down);
    assign total_feedback_div = cfg.feedback_count;
    assign load_done = s_reg.load_pulse;
endmodule

/* File: core/psl_pkg.sv */
package psl_pkg;
    typedef struct packed {
        logic        pump_gain_sel;
        logic        pump_three_state;
        logic        detector_polarity;
        logic [2:0]  aux_mux_sel;
        logic        counters_clear;
        logic [1:0]  core_current_sel;
        logic [4:0]  out_div;
        logic [12:0] feedback_count;
        logic [13:0] ref_count;
        logic [1:0]  backlash_width;
        logic        lock_precision_sel;
        logic [2:0]  lock_cycles;
        logic        factory_test_flag;
        logic [1:0]  band_clk_div;
    } psl_cfg_t;

    typedef struct packed {
        logic [2:0]  clk_sync;
        logic [2:0]  dat_sync;
        logic [2:0]  le_sync;
        logic        clk_state;
        logic        le_state;
        logic [23:0] shift;
        logic [23:0] ctrl_word;
        logic [23:0] fb_word;
        logic [23:0] ref_word;
        logic        gain;
        logic        load_pulse;
    } psl_state_t;
endpackage

/* File: test/psl_latch_bank_assertions.sv */
`timescale 1ns/1ns
// =====
// port checks
module psl_latch_bank_assertions
    import psl_pkg::*;
(
    // system
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        clk_en,
    // pins
    input wire logic        serial_clk,
    input wire logic        serial_data,
    input wire logic        load_strobe,
    input wire logic        power_down,
    // results
    input psl_cfg_t         cfg,
    input wire logic        feedback_hold_n,
    input wire logic [12:0] total_feedback_div,
    input wire logic        load_done
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_idle; !load_strobe [*8]; endsequence
    property p_total; total_feedback_div == cfg.feedback_count; endproperty
    property p_hold;
        feedback_hold_n == !(cfg.counters_clear || power_down);
    endproperty
    property p_lock;
        cfg.lock_cycles == (cfg.lock_precision_sel ? 3'h5 : 3'h3);
    endproperty
    property p_pulse; load_done |=> !load_done; endproperty
    property p_strobe; load_done |-> load_strobe; endproperty
    property p_cause; $changed(cfg) |-> load_done; endproperty
    property p_idle; s_idle |-> !load_done; endproperty
    property p_freeze; !clk_en |=> $stable(cfg); endproperty
    a_total: assert property (p_total)
        else $error("total divide differs");
    a_hold: assert property (p_hold)
        else $error("hold output wrong");
    a_lock: assert property (p_lock)
        else $error("lock cycles wrong");
    a_pulse: assert property (p_pulse)
        else $error("load pulse too long");
    a_strobe: assert property (p_strobe)
        else $error("load without strobe");
    a_cause: assert property (p_cause)
        else $error("config moved without load");
    a_idle: assert property (p_idle)
        else $error("load while strobe idle");
    a_freeze: assert property (p_freeze)
        else $error("config moved while frozen");
endmodule

/* File: test/psl_latch_bank_test.sv */
`timescale 1ns/1ns
// =====
// bench top
module psl_latch_bank_test;
    import psl_pkg::*;
    logic        clk_sys, rst_n, clk_en, power_down;
    logic        serial_clk, serial_data, load_strobe;
    logic        feedback_hold_n, load_done;
    logic [12:0] total_feedback_div;
    psl_cfg_t    cfg;
    int          bad_count = 0, check_count = 0, loads = 0, cycles = 0;

    psl_latch_bank u_dut (.clk_sys, .rst_n, .clk_en, .serial_clk,
        .serial_data, .load_strobe, .power_down, .cfg, .feedback_hold_n,
        .total_feedback_div, .load_done);
    psl_serial_master u_mst (.serial_clk, .serial_data, .load_strobe);

    initial begin
        clk_sys = 0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (load_done === 1'b1) loads <= loads + 1;
        if (cycles == 8000) begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic chk(input logic [15:0] got, exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic t_ref();
        u_mst.send(24'h36FFFD);
        chk(cfg.lock_precision_sel, 16'h1);
        chk(cfg.ref_count, 16'h3FFF);
        chk(cfg.backlash_width, 16'h2);
        chk(cfg.lock_cycles, 16'h5);
        chk(cfg.factory_test_flag, 16'h0);
        chk(cfg.band_clk_div, 16'h3);
        $display("t_ref done");
    endtask

    task automatic t_ctrl();
        u_mst.send(24'h0007B8);
        chk(cfg.pump_gain_sel, 16'h1);
        chk(cfg.pump_three_state, 16'h1);
        chk(cfg.detector_polarity, 16'h1);
        chk(cfg.aux_mux_sel, 16'h5);
        chk(feedback_hold_n, 16'h0);
        chk(cfg.counters_clear, 16'h1);
        chk(cfg.core_current_sel, 16'h2);
        chk(cfg.ref_count, 16'h3FFF);
        $display("t_ctrl done");
    endtask

    task automatic t_fb();
        u_mst.send(24'h00030A);
        chk(cfg.feedback_count, 16'h3);
        chk(total_feedback_div, 16'h3);
        chk(cfg.out_div, 16'h2);
        chk(cfg.pump_gain_sel, 16'h0);
        chk(cfg.aux_mux_sel, 16'h5);
        u_mst.send(24'h3FFF7E);
        chk(total_feedback_div, 16'h1FFF);
        chk(cfg.out_div, 16'h1F);
        chk(cfg.pump_gain_sel, 16'h1);
        $display("t_fb done");
    endtask

    task automatic t_pd();
        @(negedge clk_sys) clk_en = 1'b0;
        repeat (3) @(negedge clk_sys);
        clk_en = 1'b1;
        power_down = 1'b1;
        u_mst.send(24'h000000);
        chk(cfg.pump_gain_sel, 16'h0);
        chk(cfg.detector_polarity, 16'h0);
        chk(cfg.pump_three_state, 16'h0);
        chk(feedback_hold_n, 16'h0);
        @(negedge clk_sys) power_down = 1'b0;
        @(negedge clk_sys);
        chk(feedback_hold_n, 16'h1);
        chk(loads, 16'h5);
        $display("t_pd done");
    endtask

    // address 11 goes nowhere and gives no load pulse
    task automatic t_skip();
        u_mst.send(24'h000003);
        chk(loads, 16'h5);
        chk(cfg.ref_count, 16'h3FFF);
        chk(cfg.out_div, 16'h1F);
        $display("t_skip done");
    endtask

    initial begin
        {rst_n, clk_en, power_down} = 3'h2;
        repeat (10) @(negedge clk_sys);
        rst_n = 1'b1;
        t_ref();
        t_ctrl();
        t_fb();
        t_pd();
        t_skip();
        end_of_test();
    end
endmodule

bind psl_latch_bank psl_latch_bank_assertions u_chk (.clk_sys, .rst_n,
    .clk_en, .serial_clk, .serial_data, .load_strobe, .power_down, .cfg,
    .feedback_hold_n, .total_feedback_div, .load_done);

/* File: test/psl_serial_master.sv */
`timescale 1ns/1ns
// =====
// serial master model
module psl_serial_master (
    // serial pins
    output logic serial_clk,
    output logic serial_data,
    output logic load_strobe
);
    initial {serial_clk, serial_data, load_strobe} = 3'h0;
    // slow edges: 5 clk_sys per level so no pin pulse is lost
    task automatic send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            serial_data = w[i];
            #100 serial_clk = 1'b1;
            #100 serial_clk = 1'b0;
        end
        // data released: show inverse, not the last bit
        serial_data = ~w[0];
        #100 load_strobe = 1'b1;
        #200 load_strobe = 1'b0;
        #60;
    endtask
endmodule
